// >>> verilog/cpd_pkg.sv
// constants, codes and carrier types for the charger port-detect block
// assumes one 250 MHz clock and decoded register accesses from the serial port
package cpd_pkg;
   // clock and timing
   localparam int CLK_MHZ        = 250;
   localparam int STAT_PULSE_US  = 256;
   localparam int STAT_PULSE_CYC = STAT_PULSE_US * CLK_MHZ;
   localparam int DCD_TMO_CYC    = 3000;      // plain default, data contact wait
   localparam int WDOG_CYC       = 1000000;   // plain default, host watchdog
   // register offsets and fields
   localparam logic [7:0] DET_CTRL_OFS  = 8'h04;
   localparam logic [7:0] BIAS_CTRL_OFS = 8'h07;
   localparam int FORCE_BIT    = 4;
   localparam int CLRBIAS_BIT  = 4;
   localparam int HOSTMODE_BIT = 7;
   localparam int BIAS_BIT     = 0;
   localparam logic [7:0] RD_RESET = 8'h00;
   // number of feedback loops
   localparam int NUM_LOOPS = 6;

   // input current limit selections
   typedef enum logic [3:0] {
      LIM_100  = 4'h0,
      LIM_150  = 4'h1,
      LIM_500  = 4'h2,
      LIM_900  = 4'h3,
      LIM_1500 = 4'h4,
      LIM_2000 = 4'h5,
      LIM_EXT  = 4'h6,
      LIM_HIZ  = 4'h7,
      LIM_REG  = 4'h8
   } cpd_lim_t;

   // input voltage regulation threshold selections
   typedef enum logic [1:0] {
      INPUT_THRESHOLD_DIVIDER_PIN_436  = 2'h0,
      INPUT_THRESHOLD_DIVIDER_PIN_EXT  = 2'h1,
      INPUT_THRESHOLD_DIVIDER_PIN_NONE = 2'h2,
      INPUT_THRESHOLD_DIVIDER_PIN_REG  = 2'h3
   } cpd_input_threshold_divider_pin_t;

   // charge timer selections
   typedef enum logic [1:0] {
      TMR_6H   = 2'h0,
      TMR_45M  = 2'h1,
      TMR_NONE = 2'h2,
      TMR_REG  = 2'h3
   } cpd_tmr_t;

   // detected port kinds
   typedef enum logic [2:0] {
      PT_NONE = 3'h0,
      PT_DCP  = 3'h1,
      PT_CDP  = 3'h2,
      PT_SDP  = 3'h3,
      PT_NSA  = 3'h4
   } cpd_port_t;

   // detection states
   typedef enum logic [2:0] {
      DET_IDLE = 3'b000,
      DET_DCD  = 3'b001,
      DET_PRI  = 3'b010,
      DET_SCD  = 3'b011,
      DET_SSN  = 3'b100,
      DET_NSA  = 3'b101,
      DET_CFG  = 3'b110,
      DET_DONE = 3'b111
   } cpd_det_t;

   // one configuration set handed to the power stage
   typedef struct packed {
      cpd_lim_t  lim;
      cpd_input_threshold_divider_pin_t input_threshold_divider_pin;
      cpd_tmr_t  tmr;
   } cpd_cfg_t;
endpackage

// >>> verilog/cpd_pulse.sv
// one-shot pulse of a fixed number of clock cycles
// assumes trig is a one-cycle event on mclk
`timescale 1ns/10ps
module cpd_pulse #(
   parameter int CYCLES = 64000
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // event in, pulse out
   input  wire logic trig,
   output logic      active
);
   initial begin
      if (CYCLES < 1) $error("pulse length must be at least one cycle");
   end

   logic [31:0] cnt_r;   // cycles left in the pulse

   ////////////////////////////////////////////////////////////////////////
   // count down; a new event while busy is absorbed, giving one pulse
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 32'h0;
      end else if (trig && cnt_r == 32'h0) begin
         cnt_r <= 32'(CYCLES);
      end else if (cnt_r != 32'h0) begin
         cnt_r <= cnt_r - 32'h1;
      end
   end

   assign active = (cnt_r != 32'h0);
endmodule

// >>> verilog/cpd_top.sv
// input limit selection, host/standalone handoff and port detection
// assumes comparator results and register accesses synchronous to mclk
`timescale 1ns/10ps
module cpd_top #(
   parameter int STAT_CYC = cpd_pkg::STAT_PULSE_CYC,
   parameter int DCD_CYC  = cpd_pkg::DCD_TMO_CYC,
   parameter int WDOG_CYC = cpd_pkg::WDOG_CYC
) (
   // clock and reset
   input  wire logic                                 mclk,
   input  wire logic                                 arst_n,
   // decoded register access
   input  wire logic                                 regWr,
   input  wire logic                                 regRd,
   input  wire logic [7:0]                           regAddr,
   input  wire logic [7:0]                           regWrData,
   output logic      [7:0]                           regRdData,
   // limit pins and resistor pin shorts
   input  wire logic [2:0]                           limitSel,
   input  wire logic                                 ilimShort,
   input  wire logic                                 vdpmShort,
   input  wire logic                                 isetShort,
   // supply and battery state
   input  wire logic                                 battGood,
   input  wire logic                                 inputGood,
   input  wire logic                                 vbusPresent,
   input  wire logic                                 charging,
   input  wire logic                                 faultIn,
   // data-line comparator results
   input  wire logic                                 dcdContact,
   input  wire logic                                 priChargePort,
   input  wire logic                                 secIsDcp,
   input  wire logic                                 secIsSdp,
   input  wire logic                                 nsaPass,
   // feedback loop duty demands
   input  wire logic [cpd_pkg::NUM_LOOPS-1:0][7:0]   loopDuty,
   // configuration to power stage
   output cpd_pkg::cpd_cfg_t                         cfgOut,
   output logic                                      usb3Mode,
   output logic                                      chargeSuspend,
   output logic      [2:0]                           activeLoop,
   output logic                                      hostMode,
   output logic                                      dpBiasEn,
   // open-drain status pin
   output logic                                      statOut,
   output logic                                      statOe_n
);
   initial begin
      if (STAT_CYC < 1 || DCD_CYC < 1 || WDOG_CYC < 1)
         $error("timing counts must be at least one cycle");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   cpd_pkg::cpd_det_t  detSt_r;      // detection state
   cpd_pkg::cpd_det_t  detSt_nxt;
   cpd_pkg::cpd_port_t port_r;       // detected port kind
   cpd_pkg::cpd_cfg_t  detCfg_r;     // held detection result
   cpd_pkg::cpd_cfg_t  cfg_r;        // applied configuration
   cpd_pkg::cpd_cfg_t  cfg_nxt;
   logic        hostMode_r;          // register settings in force
   logic        wrSeen_r;            // a write arrived before supply good
   logic        supplyGood;          // battery or input good
   logic        supplyGood_r;
   logic        wdogExp;             // watchdog expiry event
   logic [31:0] wdogCnt_r;
   logic        forceDet_r;          // forced detection request
   logic        vbus_r;
   logic        vbusRise;
   logic        detGo;               // start detection
   logic [31:0] dcdCnt_r;
   logic        dcdTmo;
   logic        detDone_r;           // detection result valid
   logic        dpBias_r;
   logic        clrBiasWr;
   logic        forceWr;
   logic        usb3_r;
   logic        suspend_r;
   logic [2:0]  loop_r;
   logic [2:0]  loopMin;
   logic [7:0]  rdData_r;
   logic        faultLvl_r;
   logic        faultEvt;
   logic        pulseActive;
   logic        statOe_n_r;

   assign supplyGood = battGood | inputGood;
   assign vbusRise   = vbusPresent & ~vbus_r;
   assign forceWr    = regWr && regAddr == cpd_pkg::DET_CTRL_OFS
                       && regWrData[cpd_pkg::FORCE_BIT];
   assign clrBiasWr  = regWr && regAddr == cpd_pkg::BIAS_CTRL_OFS
                       && regWrData[cpd_pkg::CLRBIAS_BIT];
   assign wdogExp    = hostMode_r && wdogCnt_r == 32'(WDOG_CYC - 1);
   assign dcdTmo     = dcdCnt_r == 32'(DCD_CYC - 1);
   assign detGo      = vbusRise & (~hostMode_r | forceDet_r);

   ////////////////////////////////////////////////////////////////////////
   // edge history of supply, vbus and faults
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         supplyGood_r <= 1'b0;
         vbus_r       <= 1'b0;
         faultLvl_r   <= 1'b0;
      end else begin
         supplyGood_r <= supplyGood;
         vbus_r       <= vbusPresent;
         faultLvl_r   <= faultIn | isetShort;
      end
   end
   assign faultEvt = (faultIn | isetShort) & ~faultLvl_r;

   ////////////////////////////////////////////////////////////////////////
   // host mode: entered by writes, left on watchdog expiry
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hostMode_r <= 1'b0;
         wrSeen_r   <= 1'b0;
      end else begin
         if (regWr) begin
            wrSeen_r <= 1'b1;
         end
         if (wdogExp && !regWr) begin
            hostMode_r <= 1'b0;
            wrSeen_r   <= 1'b0;
         end else if (supplyGood && (regWr || (!supplyGood_r && wrSeen_r))) begin
            hostMode_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog counter, restarted by every write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wdogCnt_r <= 32'h0;
      end else if (regWr || !hostMode_r || wdogExp) begin
         wdogCnt_r <= 32'h0;
      end else begin
         wdogCnt_r <= wdogCnt_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // forced detection request; a new write wins over the hardware clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         forceDet_r <= 1'b0;
      end else if (forceWr) begin
         forceDet_r <= 1'b1;
      end else if (detGo) begin
         forceDet_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next detection state
   always_comb begin
      detSt_nxt = detSt_r;
      unique case (detSt_r)
         cpd_pkg::DET_IDLE: begin
            if (detGo) detSt_nxt = cpd_pkg::DET_DCD;
         end
         cpd_pkg::DET_DCD: begin
            if (dcdContact) detSt_nxt = cpd_pkg::DET_PRI;
            else if (dcdTmo) detSt_nxt = cpd_pkg::DET_NSA;
         end
         cpd_pkg::DET_PRI: begin
            detSt_nxt = priChargePort ? cpd_pkg::DET_SCD : cpd_pkg::DET_SSN;
         end
         cpd_pkg::DET_SCD: detSt_nxt = cpd_pkg::DET_CFG;
         cpd_pkg::DET_SSN: detSt_nxt = cpd_pkg::DET_CFG;
         cpd_pkg::DET_NSA: begin
            detSt_nxt = nsaPass ? cpd_pkg::DET_CFG : cpd_pkg::DET_PRI;
         end
         cpd_pkg::DET_CFG: detSt_nxt = cpd_pkg::DET_DONE;
         // hold until removal or new insertion
         cpd_pkg::DET_DONE: begin
            if (detGo) detSt_nxt = cpd_pkg::DET_DCD;
         end
      endcase
      if (!vbusPresent) detSt_nxt = cpd_pkg::DET_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////
   // detection state and contact timer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         detSt_r  <= cpd_pkg::DET_IDLE;
         dcdCnt_r <= 32'h0;
      end else begin
         detSt_r <= detSt_nxt;
         if (detSt_r == cpd_pkg::DET_DCD && !dcdTmo) begin
            dcdCnt_r <= dcdCnt_r + 32'h1;
         end else begin
            dcdCnt_r <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port classification
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         port_r <= cpd_pkg::PT_NONE;
      end else if (detSt_r == cpd_pkg::DET_IDLE) begin
         port_r <= cpd_pkg::PT_NONE;
      end else if (detSt_r == cpd_pkg::DET_SCD) begin
         port_r <= secIsDcp ? cpd_pkg::PT_DCP : cpd_pkg::PT_CDP;
      end else if (detSt_r == cpd_pkg::DET_SSN) begin
         // unidentified aca lands here as nonstandard
         port_r <= secIsSdp ? cpd_pkg::PT_SDP : cpd_pkg::PT_NSA;
      end else if (detSt_r == cpd_pkg::DET_NSA && nsaPass) begin
         port_r <= cpd_pkg::PT_NSA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // detection configuration, held while the port stays in
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         detCfg_r  <= '{cpd_pkg::LIM_500, cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436, cpd_pkg::TMR_6H};
         detDone_r <= 1'b0;
      end else if (detSt_r == cpd_pkg::DET_IDLE) begin
         detDone_r <= 1'b0;
      end else if (detSt_r == cpd_pkg::DET_CFG) begin
         detDone_r     <= 1'b1;
         detCfg_r.input_threshold_divider_pin <= cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436;
         unique case (port_r)
            cpd_pkg::PT_DCP: begin
               detCfg_r.lim <= ilimShort ? cpd_pkg::LIM_2000 : cpd_pkg::LIM_EXT;
               detCfg_r.tmr <= cpd_pkg::TMR_6H;
            end
            cpd_pkg::PT_CDP: begin
               detCfg_r.lim <= battGood ? cpd_pkg::LIM_1500 : cpd_pkg::LIM_100;
               detCfg_r.tmr <= battGood ? cpd_pkg::TMR_6H : cpd_pkg::TMR_45M;
            end
            cpd_pkg::PT_SDP: begin
               detCfg_r.lim <= battGood ? cpd_pkg::LIM_HIZ : cpd_pkg::LIM_100;
               detCfg_r.tmr <= battGood ? cpd_pkg::TMR_NONE : cpd_pkg::TMR_45M;
            end
            default: begin
               detCfg_r.lim <= cpd_pkg::LIM_500;
               detCfg_r.tmr <= cpd_pkg::TMR_6H;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // d+ bias for the dead battery wakeup period
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dpBias_r <= 1'b0;
      end else if (detSt_r == cpd_pkg::DET_CFG && !battGood
                   && (port_r == cpd_pkg::PT_CDP || port_r == cpd_pkg::PT_SDP)) begin
         dpBias_r <= 1'b1;
      end else if ((clrBiasWr && battGood) || !vbusPresent) begin
         dpBias_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // applied configuration: host, detection or pins
   always_comb begin
      cfg_nxt = '{cpd_pkg::LIM_500, cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436, cpd_pkg::TMR_6H};
      if (hostMode_r) begin
         cfg_nxt = '{cpd_pkg::LIM_REG, cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_REG, cpd_pkg::TMR_REG};
      end else if (detDone_r) begin
         cfg_nxt = detCfg_r;
      end else begin
         unique case (limitSel[1:0])
            2'b00: cfg_nxt.lim = limitSel[2] ? cpd_pkg::LIM_900 : cpd_pkg::LIM_500;
            2'b10: cfg_nxt.lim = limitSel[2] ? cpd_pkg::LIM_150 : cpd_pkg::LIM_100;
            2'b01: begin
               cfg_nxt.lim  = ilimShort ? cpd_pkg::LIM_2000 : cpd_pkg::LIM_EXT;
               cfg_nxt.input_threshold_divider_pin = vdpmShort ? cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436 : cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_EXT;
            end
            2'b11: begin
               cfg_nxt.lim  = cpd_pkg::LIM_HIZ;
               cfg_nxt.input_threshold_divider_pin = cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_NONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // smallest duty demand wins
   always_comb begin
      loopMin = 3'h0;
      for (int i = 1; i < cpd_pkg::NUM_LOOPS; i++) begin
         if (loopDuty[i] < loopDuty[loopMin]) loopMin = 3'(i);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs to the power stage
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r     <= '{cpd_pkg::LIM_500, cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436, cpd_pkg::TMR_6H};
         usb3_r    <= 1'b0;
         suspend_r <= 1'b0;
         loop_r    <= 3'h0;
      end else begin
         cfg_r     <= cfg_nxt;
         usb3_r    <= limitSel[2];
         suspend_r <= isetShort;
         loop_r    <= loopMin;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read data
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_r <= cpd_pkg::RD_RESET;
      end else if (regRd) begin
         rdData_r <= cpd_pkg::RD_RESET;
         if (regAddr == cpd_pkg::DET_CTRL_OFS) begin
            rdData_r[cpd_pkg::HOSTMODE_BIT] <= hostMode_r;
            rdData_r[cpd_pkg::FORCE_BIT]    <= forceDet_r;
            rdData_r[2:0]                   <= port_r;
         end else if (regAddr == cpd_pkg::BIAS_CTRL_OFS) begin
            rdData_r[cpd_pkg::BIAS_BIT] <= dpBias_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault pulse on status pin
   cpd_pulse #(
      .CYCLES (STAT_CYC)
   ) uFaultPulse (
      .mclk   (mclk),
      .arst_n (arst_n),
      .trig   (faultEvt),
      .active (pulseActive)
   );

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         statOe_n_r <= 1'b1;
      end else begin
         statOe_n_r <= ~(pulseActive | (charging & ~suspend_r));
      end
   end

   assign cfgOut        = cfg_r;
   assign usb3Mode      = usb3_r;
   assign chargeSuspend = suspend_r;
   assign activeLoop    = loop_r;
   assign hostMode      = hostMode_r;
   assign dpBiasEn      = dpBias_r;
   assign regRdData     = rdData_r;
   assign statOut       = 1'b0;
   assign statOe_n      = statOe_n_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_pin_default: assert property (@(posedge mclk) disable iff (!arst_n)
      (!hostMode_r && !detDone_r && limitSel == 3'b000)
      |=> cfg_r.lim == cpd_pkg::LIM_500 && cfg_r.input_threshold_divider_pin == cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436)
      else $error("pin pattern 000 not applied");

   a_input_limit_resistor_pin_short: assert property (@(posedge mclk) disable iff (!arst_n)
      (!hostMode_r && !detDone_r && limitSel[1:0] == 2'b01 && ilimShort)
      |=> cfg_r.lim == cpd_pkg::LIM_2000)
      else $error("shorted limit pin default missing");

   a_charge_current_resistor_pin_suspend: assert property (@(posedge mclk) disable iff (!arst_n)
      isetShort |=> chargeSuspend)
      else $error("charging not suspended");

   a_wdog_exit: assert property (@(posedge mclk) disable iff (!arst_n)
      (wdogExp && !regWr) |=> !hostMode)
      else $error("host mode kept after watchdog");

   a_dcd_entry: assert property (@(posedge mclk) disable iff (!arst_n)
      (detSt_r == cpd_pkg::DET_IDLE && vbusRise && !hostMode_r)
      |=> detSt_r == cpd_pkg::DET_DCD)
      else $error("contact detect not entered");

   a_dcd_timeout: assert property (@(posedge mclk) disable iff (!arst_n)
      (detSt_r == cpd_pkg::DET_DCD && dcdTmo && !dcdContact && vbusPresent)
      |=> detSt_r == cpd_pkg::DET_NSA)
      else $error("timeout did not reach nonstandard check");

   a_dead_cdp: assert property (@(posedge mclk) disable iff (!arst_n)
      (detSt_r == cpd_pkg::DET_CFG && port_r == cpd_pkg::PT_CDP && !battGood
       && vbusPresent && !hostMode_r)
      |=> ##1 cfg_r.lim == cpd_pkg::LIM_100 && cfg_r.tmr == cpd_pkg::TMR_45M)
      else $error("dead battery cdp setting wrong");

   a_bias_clear: assert property (@(posedge mclk) disable iff (!arst_n)
      (clrBiasWr && battGood && detSt_r != cpd_pkg::DET_CFG) |=> !dpBiasEn)
      else $error("d+ bias not cleared");

   a_fault_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
      (faultEvt && !pulseActive) |=> ##1 !statOe_n [*8])
      else $error("fault pulse not driven");

   a_loop_min: assert property (@(posedge mclk) disable iff (!arst_n)
      $stable(loopDuty) |-> loopDuty[activeLoop] <= loopDuty[0]
      && loopDuty[activeLoop] <= loopDuty[1] && loopDuty[activeLoop] <= loopDuty[2]
      && loopDuty[activeLoop] <= loopDuty[3] && loopDuty[activeLoop] <= loopDuty[4]
      && loopDuty[activeLoop] <= loopDuty[5])
      else $error("active loop not minimum");
endmodule

// >>> test/cpd_port_model.sv
// charging port model: data-line comparator results per port kind
// assumes kind is stable for the whole of one insertion
`timescale 1ns/10ps
module cpd_port_model (
   // clock and port state
   input  wire logic               mclk,
   input  wire logic               vbus,
   input  wire cpd_pkg::cpd_port_t kind,
   // comparator results
   output logic                    dcdContact,
   output logic                    priChargePort,
   output logic                    secIsDcp,
   output logic                    secIsSdp,
   output logic                    nsaPass
);
   logic junk = 1'b0;   // changing level while unplugged
   ////////////////////////////////////////////////////////////////////////
   // a detached port never holds a steady level
   always @(posedge mclk) junk <= ~junk;
   // results follow the attached kind; nonstandard never makes contact
   always_comb begin
      if (vbus) begin
         dcdContact    = (kind != cpd_pkg::PT_NSA);
         priChargePort = (kind == cpd_pkg::PT_DCP) || (kind == cpd_pkg::PT_CDP);
         secIsDcp      = (kind == cpd_pkg::PT_DCP);
         secIsSdp      = (kind == cpd_pkg::PT_SDP);
         nsaPass       = (kind == cpd_pkg::PT_NSA);
      end else begin
         {dcdContact, priChargePort, secIsDcp, secIsSdp, nsaPass} = {5{junk}};
      end
   end
endmodule

// >>> test/charger_input_limit_and_port_detect_tb.sv
// bench for the limit select, handoff and port detection block
// assumes short timing parameters and the port model on the data lines
`timescale 1ns/10ps
module charger_input_limit_and_port_detect_tb;
   localparam int SC = 16, DC = 8, WC = 50;   // shortened counts
   localparam cpd_pkg::cpd_lim_t PL[8] = '{cpd_pkg::LIM_500, cpd_pkg::LIM_EXT,
      cpd_pkg::LIM_100, cpd_pkg::LIM_HIZ, cpd_pkg::LIM_900, cpd_pkg::LIM_EXT,
      cpd_pkg::LIM_150, cpd_pkg::LIM_HIZ};
   localparam cpd_pkg::cpd_port_t DK[6] = '{cpd_pkg::PT_DCP, cpd_pkg::PT_CDP,
      cpd_pkg::PT_CDP, cpd_pkg::PT_SDP, cpd_pkg::PT_SDP, cpd_pkg::PT_NSA};
   localparam cpd_pkg::cpd_lim_t DL[6] = '{cpd_pkg::LIM_EXT, cpd_pkg::LIM_1500,
      cpd_pkg::LIM_100, cpd_pkg::LIM_HIZ, cpd_pkg::LIM_100, cpd_pkg::LIM_500};
   localparam cpd_pkg::cpd_tmr_t DT[6] = '{cpd_pkg::TMR_6H, cpd_pkg::TMR_6H,
      cpd_pkg::TMR_45M, cpd_pkg::TMR_NONE, cpd_pkg::TMR_45M, cpd_pkg::TMR_6H};
   localparam logic [0:5] DB = 6'b110101;     // battery good per case
   logic                                   mclk = 1'b0, arst_n = 1'b0;
   logic                                   regWr = 1'b0, regRd = 1'b0;
   logic [7:0]                             regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
   logic [2:0]                             limitSel = 3'h0, activeLoop;
   logic                                   ilimShort = 1'b0, vdpmShort = 1'b0;
   logic                                   isetShort = 1'b0, faultIn = 1'b0, charging = 1'b0;
   logic                                   battGood = 1'b1, inputGood = 1'b1, vbusPresent = 1'b0;
   logic                                   dcdContact, priChargePort, secIsDcp, secIsSdp, nsaPass;
   logic [cpd_pkg::NUM_LOOPS-1:0][7:0]     loopDuty = '0;
   cpd_pkg::cpd_cfg_t                      cfgOut;
   cpd_pkg::cpd_port_t                     kind = cpd_pkg::PT_NONE;
   logic                                   usb3Mode, chargeSuspend, hostMode, dpBiasEn;
   logic                                   statOut, statOe_n;
   int                                     mismatches = 0, checks = 0, cyc = 0, n;
   cpd_top #(.STAT_CYC(SC), .DCD_CYC(DC), .WDOG_CYC(WC)) dut (.mclk, .arst_n, .regWr, .regRd,
      .regAddr, .regWrData, .regRdData, .limitSel, .ilimShort, .vdpmShort, .isetShort,
      .battGood, .inputGood, .vbusPresent, .charging, .faultIn, .dcdContact, .priChargePort,
      .secIsDcp, .secIsSdp, .nsaPass, .loopDuty, .cfgOut, .usb3Mode, .chargeSuspend,
      .activeLoop, .hostMode, .dpBiasEn, .statOut, .statOe_n);
   cpd_port_model port (.mclk, .vbus(vbusPresent), .kind, .dcdContact, .priChargePort,
      .secIsDcp, .secIsSdp, .nsaPass);
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // helpers: settle past the edge, bus cycles, compare, verdict
   task automatic step(input int k); repeat (k) @(posedge mclk); #1; endtask
   task automatic wr(input logic [7:0] a, v);
      regAddr = a; regWrData = v; regWr = 1'b1; step(1); regWr = 1'b0; step(1);
   endtask
   task automatic rd(input logic [7:0] a);
      regAddr = a; regRd = 1'b1; step(1); regRd = 1'b0; d = regRdData; step(1);
   endtask
   task automatic chk(input logic [7:0] got, exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic detect(input cpd_pkg::cpd_port_t k);
      kind = k; vbusPresent = 1'b1; step(30);
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      step(3); arst_n = 1'b1;
      chk(8'(statOe_n), 8'h01);
      chk(8'(statOut), 8'h00);
      for (int p = 0; p < 8; p++) begin
         limitSel = 3'(p); step(2);
         chk(8'(cfgOut.lim), 8'(PL[p]));
         chk(8'(cfgOut.input_threshold_divider_pin), 8'(p[0] ? (p[1] ? cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_NONE : cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_EXT)
            : cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436));
         chk(8'(usb3Mode), 8'(p[2]));
      end
      limitSel = 3'h1; ilimShort = 1'b1; vdpmShort = 1'b1; step(2);
      chk(8'(cfgOut.lim), 8'(cpd_pkg::LIM_2000));
      chk(8'(cfgOut.input_threshold_divider_pin), 8'(cpd_pkg::INPUT_THRESHOLD_DIVIDER_PIN_436));
      limitSel = 3'h0; ilimShort = 1'b0; vdpmShort = 1'b0;
      for (int j = 0; j < 6; j++) begin
         for (int i = 0; i < 6; i++) loopDuty[i] = (i >= j) ? 8'h20 : 8'h60;
         step(2); chk(8'(activeLoop), 8'(j));
      end
      charging = 1'b1; step(3); chk(8'(statOe_n), 8'h00);
      charging = 1'b0; step(3); chk(8'(statOe_n), 8'h01);
      for (int s = 0; s < 2; s++) begin
         {isetShort, faultIn} = 2'(s + 1); step(1);
         chk(8'(chargeSuspend), 8'(s));
         n = 0; while (statOe_n !== 1'b0 && n < 5) begin step(1); n++; end
         n = 0; while (statOe_n === 1'b0 && n < 99) begin step(1); n++; end
         chk(8'(n), 8'(SC));
         {isetShort, faultIn} = 2'h0; step(2);
      end
      for (int i = 0; i < 6; i++) begin
         battGood = DB[i]; detect(DK[i]);
         chk(8'(cfgOut.lim), 8'(DL[i]));
         chk(8'(cfgOut.tmr), 8'(DT[i]));
         chk(8'(dpBiasEn), 8'(!DB[i]));
         rd(8'h04); chk(8'(d[2:0]), 8'(DK[i]));
         limitSel = 3'h2; step(2); chk(8'(cfgOut.lim), 8'(DL[i]));
         limitSel = 3'h0; vbusPresent = 1'b0; step(3);
      end
      battGood = 1'b0; detect(cpd_pkg::PT_CDP);
      wr(8'h07, 8'h10); chk(8'(dpBiasEn), 8'h01);
      rd(8'h07); chk(d, 8'h01);
      // port held attached past the clear
      battGood = 1'b1; wr(8'h07, 8'h10); chk(8'(dpBiasEn), 8'h00);
      chk(8'(hostMode), 8'h01);
      chk(8'(cfgOut.lim), 8'(cpd_pkg::LIM_REG));
      vbusPresent = 1'b0; step(3); detect(cpd_pkg::PT_DCP);
      rd(8'h04); chk(d, 8'h80);
      vbusPresent = 1'b0; step(3); wr(8'h04, 8'h10); rd(8'h04); chk(d, 8'h90);
      detect(cpd_pkg::PT_DCP); rd(8'h04); chk(d, 8'h81);
      step(WC); chk(8'(hostMode), 8'h00);
      {battGood, inputGood} = 2'h0; wr(8'h00, 8'h00); chk(8'(hostMode), 8'h00);
      inputGood = 1'b1; step(2); chk(8'(hostMode), 8'h01);
      rd(8'h00); chk(d, 8'h00);
      report_and_stop();
   end
endmodule
